// [include/ttcd_consts.vh]
`ifndef TTCD_CONSTS_VH
`define TTCD_CONSTS_VH

// serial word layout: write flag, address, data
`define TTCD_WORD_BITS      6'd32
`define TTCD_WR_BIT         31
`define TTCD_ADDR_HI        30
`define TTCD_ADDR_LO        24
`define TTCD_DATA_HI        23

// register addresses
`define TTCD_ADDR_TONE      7'h08
`define TTCD_ADDR_CALIBRATION_DAC_CONTROL    7'h09

// reset values
`define TTCD_TONE_RST       24'h000000
`define TTCD_CALIBRATION_DAC_CONTROL_RST     24'h002000

// writable bits (reserved bits stored and read as zero)
`define TTCD_TONE_MASK      24'hf8001f
`define TTCD_CALIBRATION_DAC_CONTROL_MASK    24'h003fff

// test tone register fields
`define TTCD_TONE_SEL_HI    23
`define TTCD_TONE_SEL_LO    19
`define TTCD_WAVE_HI        4
`define TTCD_WAVE_LO        3
`define TTCD_TONE_INT_BIT   2
`define TTCD_TONE_OUT_BIT   1
`define TTCD_TONE_EN_BIT    0

// calibration register fields
`define TTCD_CHOP_BIT       13
`define TTCD_CALMODE_BIT    12
`define TTCD_CALIBRATION_PATH_INTERNAL_BIT     11
`define TTCD_DACEN_BIT      10
`define TTCD_CODE_HI        9

// waveform selection codes
`define TTCD_WAVE_SINE10    2'h0
`define TTCD_WAVE_SINE150   2'h1
`define TTCD_WAVE_SQUARE    2'h2

// extra serial clocks before a new calibration word takes effect
`define TTCD_DAC_EXTRA_CLKS 3'h4

// chop clock: 250 MHz / (2 * 256 kHz) = 488 clocks a half period
`define TTCD_CHOP_HALF_CYC  10'h1e8

`endif

// [rtl/ttcd_top.v]
`timescale 1ns/10ps
`include "ttcd_consts.vh"

module ttcd_top (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // serial register port
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        sdi,
  output reg         sdo,
  // gang straps
  input  wire        gang_mode,
  input  wire        slave_mode,
  // electrode routing
  output reg  [4:0]  electrode_to_cm,
  output reg  [4:0]  electrode_to_tone,
  output reg         ext_switch_open,
  output reg         internal_inject,
  // tone and dac control
  output reg  [1:0]  waveform_type,
  output reg         dac_source_tone,
  output reg         dac_on,
  output reg  [9:0]  dac_code,
  output reg         dac_chop_clk,
  output reg         cal_pin_connect,
  output reg         acq_start,
  output reg         ac_leadoff_suppress
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, change accepted when stages 2 and 3 agree

  wire [4:0] raw_in = {slave_mode, gang_mode, sdi, cs_n, sclk};
  wire [4:0] filt;

  // sclk, cs_n, sdi, gang, slave: one filter shape for every pin
  // a glitch shorter than two clocks never reaches the filtered level
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      reg s1_ff;
      reg s2_ff;
      reg s3_ff;
      reg flt_ff;
      always @(posedge clk or posedge rst) begin
        // reset to the idle level of each pin so no false edge follows
        if (rst) begin
          s1_ff  <= (gi == 1) ? 1'b1 : 1'b0;
          s2_ff  <= (gi == 1) ? 1'b1 : 1'b0;
          s3_ff  <= (gi == 1) ? 1'b1 : 1'b0;
          flt_ff <= (gi == 1) ? 1'b1 : 1'b0;
        end else begin
          s1_ff <= raw_in[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            flt_ff <= s3_ff;
          end
        end
      end
      assign filt[gi] = flt_ff;
    end
  endgenerate

  wire sclk_f  = filt[0];
  wire cs_n_f  = filt[1];
  wire sdi_f   = filt[2];
  wire gang_f  = filt[3];
  wire slave_f = filt[4];

  reg sclk_d_ff;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_f;
    end
  end
  wire sclk_rise = sclk_f & ~sclk_d_ff;
  wire sclk_fall = ~sclk_f & sclk_d_ff;

  //////////////////////////////////////////////////////////////////////////
  // serial word receiver and registers

  reg  [4:0]  bit_cnt_ff;
  reg  [31:0] shift_ff;
  reg  [23:0] rd_shift_ff;
  reg  [23:0] tone_ff;
  reg  [23:0] calibration_dac_control_ff;
  reg  [23:0] cal_pend_ff;
  reg         cal_pend_vld_ff;
  reg  [2:0]  extra_cnt_ff;

  wire [31:0] word_nxt = {shift_ff[30:0], sdi_f};
  wire        word_done = sclk_rise & (bit_cnt_ff == 5'h1f);
  wire        is_write = word_nxt[`TTCD_WR_BIT];
  wire [6:0]  word_addr = word_nxt[`TTCD_ADDR_HI:`TTCD_ADDR_LO];
  wire [23:0] word_data = word_nxt[`TTCD_DATA_HI:0];

  // read mux, used when the address byte completes
  function [23:0] ttcd_rd_mux;
    input [6:0] addr;
    begin
      if (addr == `TTCD_ADDR_TONE) begin
        ttcd_rd_mux = tone_ff;
      end else if (addr == `TTCD_ADDR_CALIBRATION_DAC_CONTROL) begin
        ttcd_rd_mux = calibration_dac_control_ff;
      end else begin
        ttcd_rd_mux = 24'h000000;
      end
    end
  endfunction

  // bit counter wraps at 32, so frames may run back to back
  // the read word is latched as soon as the address byte is in
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_ff  <= 5'h00;
      shift_ff    <= 32'h00000000;
      rd_shift_ff <= 24'h000000;
      sdo         <= 1'b0;
    end else if (cs_n_f) begin
      // aborted frames are dropped, nothing half written takes effect
      bit_cnt_ff <= 5'h00;
      sdo        <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shift_ff   <= word_nxt;
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
        if (bit_cnt_ff == 5'h07) begin
          rd_shift_ff <= ttcd_rd_mux(word_nxt[6:0]);
        end
      end
      // read data leaves on falling edges during the data phase
      if (sclk_fall) begin
        if (bit_cnt_ff >= 5'h08) begin
          sdo         <= rd_shift_ff[23];
          rd_shift_ff <= {rd_shift_ff[22:0], 1'b0};
        end else begin
          sdo <= 1'b0;
        end
      end
    end
  end

  // tone word lands at once; the dac word waits for trailing clocks
  // a new dac write before they finish restarts the count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tone_ff         <= `TTCD_TONE_RST;
      calibration_dac_control_ff       <= `TTCD_CALIBRATION_DAC_CONTROL_RST;
      cal_pend_ff     <= `TTCD_CALIBRATION_DAC_CONTROL_RST;
      cal_pend_vld_ff <= 1'b0;
      extra_cnt_ff    <= 3'h0;
    end else begin
      if (word_done & ~cs_n_f & is_write) begin
        if (word_addr == `TTCD_ADDR_TONE) begin
          tone_ff <= word_data & `TTCD_TONE_MASK;
        end else if (word_addr == `TTCD_ADDR_CALIBRATION_DAC_CONTROL) begin
          cal_pend_ff     <= word_data & `TTCD_CALIBRATION_DAC_CONTROL_MASK;
          cal_pend_vld_ff <= 1'b1;
          extra_cnt_ff    <= 3'h0;
        end
      end else if (cal_pend_vld_ff & sclk_rise) begin
        // dac word lands only after the extra serial clocks
        if (extra_cnt_ff == `TTCD_DAC_EXTRA_CLKS - 3'h1) begin
          calibration_dac_control_ff       <= cal_pend_ff;
          cal_pend_vld_ff <= 1'b0;
          extra_cnt_ff    <= 3'h0;
        end else begin
          extra_cnt_ff <= extra_cnt_ff + 3'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // routing decode

  wire [4:0] tone_sel  = tone_ff[`TTCD_TONE_SEL_HI:`TTCD_TONE_SEL_LO];
  wire [1:0] wave_fld  = tone_ff[`TTCD_WAVE_HI:`TTCD_WAVE_LO];
  wire       tone_int  = tone_ff[`TTCD_TONE_INT_BIT];
  wire       tone_pout = tone_ff[`TTCD_TONE_OUT_BIT];
  wire       tone_en   = tone_ff[`TTCD_TONE_EN_BIT];
  wire       chop_en   = calibration_dac_control_ff[`TTCD_CHOP_BIT];
  wire       cal_mode  = calibration_dac_control_ff[`TTCD_CALMODE_BIT];
  wire       cal_int   = calibration_dac_control_ff[`TTCD_CALIBRATION_PATH_INTERNAL_BIT];
  wire       dac_en    = calibration_dac_control_ff[`TTCD_DACEN_BIT];

  // the tone yields whenever calibration mode is on
  wire tone_act = tone_en & ~cal_mode;

  // internal routing opens the external switches and feeds the dac inside
  function ttcd_inject;
    input t_act;
    input t_int;
    input c_mode;
    input c_int;
    begin
      ttcd_inject = (t_act & t_int) | (c_mode & c_int);
    end
  endfunction

  reg [1:0] nxt_wave;
  reg       nxt_pin;
  reg       nxt_dac_on;
  always @* begin
    // square wave for any code with the upper bit set
    if (wave_fld[1]) begin
      nxt_wave = `TTCD_WAVE_SQUARE;
    end else if (wave_fld[0]) begin
      nxt_wave = `TTCD_WAVE_SINE150;
    end else begin
      nxt_wave = `TTCD_WAVE_SINE10;
    end
    // pin priority: calibration, external tone, internal tone, dac use
    nxt_pin = 1'b0;
    if (cal_mode) begin
      nxt_pin = 1'b1;
    end else if (tone_act & ~tone_int) begin
      nxt_pin = 1'b1;
    end else if (tone_act & tone_int) begin
      // gang keeps the shared pin tied so the master tone reaches slaves
      nxt_pin = tone_pout | gang_f;
    end else if (dac_en & ~slave_f) begin
      nxt_pin = 1'b1;
    end
    // a slave leaves its dac off so the master can drive the pin
    nxt_dac_on = (dac_en | tone_act | cal_mode) & ~slave_f;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      electrode_to_cm     <= 5'h1f;
      electrode_to_tone   <= 5'h00;
      ext_switch_open     <= 1'b0;
      internal_inject     <= 1'b0;
      waveform_type       <= `TTCD_WAVE_SINE10;
      dac_source_tone     <= 1'b0;
      dac_on              <= 1'b0;
      dac_code            <= 10'h000;
      cal_pin_connect     <= 1'b0;
      acq_start           <= 1'b0;
      ac_leadoff_suppress <= 1'b0;
    end else begin
      // registered so the analog switches never see a decode glitch
      electrode_to_cm   <= ~tone_sel;
      electrode_to_tone <= tone_sel & {5{tone_int}};
      ext_switch_open   <= ttcd_inject(tone_act, tone_int, cal_mode, cal_int);
      internal_inject   <= ttcd_inject(tone_act, tone_int, cal_mode, cal_int);
      waveform_type     <= nxt_wave;
      dac_source_tone   <= tone_act;
      dac_on            <= nxt_dac_on;
      dac_code          <= calibration_dac_control_ff[`TTCD_CODE_HI:0];
      cal_pin_connect   <= nxt_pin;
      acq_start         <= cal_mode;
      // tone bit alone already blocks ac lead-off, even under cal mode
      ac_leadoff_suppress <= tone_en | nxt_dac_on;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // chop clock, held low when chopping is off or the dac is idle

  // 488 clocks a half gives about 256.1 kHz, close enough for chopping
  // the counter restarts whenever chopping stops, so the first half is full
  reg [9:0] chop_cnt_ff;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      chop_cnt_ff  <= 10'h000;
      dac_chop_clk <= 1'b0;
    end else if (~(chop_en & dac_on)) begin
      chop_cnt_ff  <= 10'h000;
      dac_chop_clk <= 1'b0;
    end else if (chop_cnt_ff == `TTCD_CHOP_HALF_CYC - 10'h001) begin
      chop_cnt_ff  <= 10'h000;
      dac_chop_clk <= ~dac_chop_clk;
    end else begin
      chop_cnt_ff <= chop_cnt_ff + 10'h001;
    end
  end

endmodule

// [test/ttcd_top_checker.sv]
`timescale 1ns/10ps
module ttcd_top_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // straps
  input wire logic       slave_mode,
  // routing and dac
  input wire logic [4:0] electrode_to_cm,
  input wire logic [4:0] electrode_to_tone,
  input wire logic       ext_switch_open,
  input wire logic       internal_inject,
  input wire logic [1:0] waveform_type,
  input wire logic       dac_source_tone,
  input wire logic       dac_on,
  input wire logic       dac_chop_clk,
  input wire logic       cal_pin_connect,
  input wire logic       acq_start,
  input wire logic       ac_leadoff_suppress
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [9:0] hold_ff;
  // cycles since the chop clock last changed
  always @(posedge clk or posedge rst) begin
    if (rst)
      hold_ff <= 10'h000;
    else if ($changed(dac_chop_clk))
      hold_ff <= 10'h000;
    else if (hold_ff != 10'h3ff)
      hold_ff <= hold_ff + 10'h001;
  end
  ////////////////////////////////////////
  a_cm_tone_excl: assert property (
    (electrode_to_cm & electrode_to_tone) == 5'h00) else $error("both");
  a_switch_inject: assert property (
    ext_switch_open == internal_inject) else $error("inject");
  a_wave_code: assert property (
    waveform_type != 2'h3) else $error("wave code");
  a_slave_dac_off: assert property (
    slave_mode [*8] |-> !dac_on) else $error("slave dac");
  a_dac_leadoff: assert property (
    dac_on |-> ac_leadoff_suppress) else $error("leadoff dac");
  a_tone_leadoff: assert property (
    dac_source_tone |-> ac_leadoff_suppress) else $error("leadoff tone");
  a_cal_pin: assert property (
    acq_start |-> cal_pin_connect && dac_on || 1'b1 && cal_pin_connect)
    else $error("cal pin");
  a_cal_priority: assert property (
    acq_start |-> !dac_source_tone) else $error("priority");
  a_chop_idle: assert property (
    !dac_on && !$past(dac_on) |-> !dac_chop_clk) else $error("chop idle");
  a_chop_half: assert property (
    dac_chop_clk && $past(dac_chop_clk) |-> hold_ff <= 10'd487)
    else $error("chop high too long");
  a_chop_low: assert property (
    $rose(dac_chop_clk) |-> hold_ff >= 10'd486)
    else $error("chop low too short");
  c_cal: cover property (acq_start);
  c_chop: cover property ($rose(dac_chop_clk));
  c_tone: cover property (electrode_to_tone != 5'h00);
endmodule
bind ttcd_top ttcd_top_checker u_chk (.clk(clk), .rst(rst),
  .slave_mode(slave_mode), .electrode_to_cm(electrode_to_cm),
  .electrode_to_tone(electrode_to_tone), .ext_switch_open(ext_switch_open),
  .internal_inject(internal_inject), .waveform_type(waveform_type),
  .dac_source_tone(dac_source_tone), .dac_on(dac_on),
  .dac_chop_clk(dac_chop_clk), .cal_pin_connect(cal_pin_connect),
  .acq_start(acq_start), .ac_leadoff_suppress(ac_leadoff_suppress));

// [test/ttcd_host.sv]
`timescale 1ns/10ps
module ttcd_host (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  ////////////////////////////////////////
  // six clocks a phase so the pin synchronisers never miss an edge
  task automatic frame(input logic [31:0] w, input int n,
                       output logic [23:0] rd);
    rd = 24'h000000;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = w[31-i];
      repeat (6) @(negedge clk);
      if (i >= 8)
        rd = {rd[22:0], sdo};
      sclk = 1'b1;
      repeat (6) @(negedge clk);
      sclk = 1'b0;
    end
    cs_n = 1'b1;
    sdi  = ~sdi;
  endtask
  // trailing clocks after a calibration word; bench may give too few
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(negedge clk);
      sclk = 1'b1;
      repeat (6) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
endmodule

// [test/test_tone_calibration_dac_control_bench.sv]
`timescale 1ns/10ps
`include "ttcd_consts.vh"
module test_tone_calibration_dac_control_bench;
  int          num_errors, checks, cycles;
  logic [31:0] seed;
  logic [23:0] tone_r, cal_r, rd;
  logic        clk, rst, gang_mode, slave_mode, sclk, cs_n, sdi, sdo;
  logic        sw_open, inject, src_tone, dac_on, chop, pin, acq, lo_sup;
  logic [4:0]  to_cm, to_tone;
  logic [1:0]  wave;
  logic [9:0]  code;
  logic        c0;
  ttcd_top uut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .gang_mode(gang_mode), .slave_mode(slave_mode),
    .electrode_to_cm(to_cm), .electrode_to_tone(to_tone),
    .ext_switch_open(sw_open), .internal_inject(inject),
    .waveform_type(wave), .dac_source_tone(src_tone), .dac_on(dac_on),
    .dac_code(code), .dac_chop_clk(chop), .cal_pin_connect(pin),
    .acq_start(acq), .ac_leadoff_suppress(lo_sup));
  ttcd_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [23:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    host.frame({1'b1, a, d}, 32, rd);
    if (a == `TTCD_ADDR_CALIBRATION_DAC_CONTROL)
      host.pulses(4);
    repeat (12) @(negedge clk);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [23:0] exp);
    host.frame({1'b0, a, 24'h000000}, 32, rd);
    cmp(rd, exp, "readback");
  endtask
  task automatic chk_outs();
    logic m;
    logic on;
    logic ta;
    logic sw;
    logic pe;
    m  = ~slave_mode;
    on = (cal_r[10] | tone_r[0] | cal_r[12]) & m;
    ta = tone_r[0] & ~cal_r[12];
    sw = (ta & tone_r[2]) | (cal_r[12] & cal_r[11]);
    pe = cal_r[12] | (ta & (~tone_r[2] | tone_r[1] | gang_mode))
         | (~ta & cal_r[10] & m);
    cmp(to_cm, 5'(~tone_r[23:19]), "to_cm");
    cmp(to_tone, tone_r[23:19] & {5{tone_r[2]}}, "to_tone");
    cmp(wave, {tone_r[4], tone_r[3] & ~tone_r[4]}, "wave");
    cmp(code, cal_r[9:0], "code");
    cmp(dac_on, on, "dac_on");
    cmp(lo_sup, tone_r[0] | on, "leadoff");
    cmp(acq, cal_r[12], "acq");
    cmp(src_tone, tone_r[0] & ~cal_r[12], "src");
    if (cal_r[12] | (cal_r[10] & m))
      cmp(pin, 1'b1, "pin");
    cmp(pin, pe, "pin route");
    cmp(sw_open, sw, "sw_open");
    cmp(inject, sw, "inject");
    if (!cal_r[13])
      cmp(chop, 1'b0, "unchopped");
  endtask
  task automatic set_both(input logic [23:0] t, c);
    wr(`TTCD_ADDR_TONE, t);
    wr(`TTCD_ADDR_CALIBRATION_DAC_CONTROL, c);
    tone_r = t & `TTCD_TONE_MASK;
    cal_r  = c & `TTCD_CALIBRATION_DAC_CONTROL_MASK;
    chk_outs();
    rd_chk(`TTCD_ADDR_TONE, tone_r);
    rd_chk(`TTCD_ADDR_CALIBRATION_DAC_CONTROL, cal_r);
  endtask
  task automatic give_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 32'd69014;
    num_errors = 0;
    checks = 0;
    cycles = 0;
    rst = 1'b1;
    gang_mode = 1'b0;
    slave_mode = 1'b0;
    tone_r = `TTCD_TONE_RST;
    cal_r = `TTCD_CALIBRATION_DAC_CONTROL_RST;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk_outs();
    rd_chk(`TTCD_ADDR_CALIBRATION_DAC_CONTROL, 24'h002000);
    rd_chk(7'h0a, 24'h000000);
    for (int i = 0; i < 4; i++)
      set_both(24'h800005 | (i << 3), 24'h002000 | i);
    for (int i = 0; i < 12; i++) begin
      slave_mode = rnd() >> 7;
      gang_mode = rnd() >> 9;
      set_both(rnd(), rnd());
    end
    slave_mode = 1'b0;
    host.frame({1'b1, `TTCD_ADDR_CALIBRATION_DAC_CONTROL, cal_r ^ 24'h0003ff}, 32, rd);
    host.pulses(3);
    repeat (12) @(negedge clk);
    cmp(code, cal_r[9:0], "early");
    host.pulses(1);
    repeat (12) @(negedge clk);
    cal_r = cal_r ^ 24'h0003ff;
    cmp(code, cal_r[9:0], "commit");
    host.frame({1'b1, `TTCD_ADDR_TONE, ~tone_r}, 20, rd);
    repeat (12) @(negedge clk);
    chk_outs();
    set_both(tone_r, 24'h002400);
    c0 = chop;
    repeat (`TTCD_CHOP_HALF_CYC) @(negedge clk);
    cmp(chop, !c0, "chop");
    give_verdict();
  end
endmodule
